/* design/ldcr_pkg.sv */
// Constants for the LED driver configuration register bank.
// Assumes a byte-wide register port fed by an SMBus/I2C protocol engine.
// Overview of operation
// - Identification register is read-only: bit 7 one, maker code, silicon step.
// - Silicon step reads zero on first silicon, rises by one per spin.
// - Maker values 10 to 14 reserved; 15 means no maker code.
// - DC current level scales sink current linearly in 256 steps, live.
// - During PWM on-intervals the sink current follows the DC current level.
// - DC current level reads back as stored and resets to all ones.
// - Two-bit FET drive strength selects 25, 50, 75 or 100 percent.
// - Configuration bit 2 picks 1.2 MHz when zero, 600 kHz when one.
// - Configuration bit 0 enables string short detection at 7.5 V.
// - Configuration register resets to 0x1f.
// - Channel mask bit n enables LED channel n, n from 0 to 5.
// - Mask read gives zero for disabled or faulted channels, else one.
// - Disabling then re-enabling a faulted channel retries only that channel.
// - Channel mask resets with all six channel bits set.
// - Bit 7 set: each enabled channel lags the previous by period over count.
// - Bit 7 clear: each enabled channel lags the previous by code times period over 255.
// - Phase-shift register resets to zero, giving no delay.
// - Writing 0x80 to oscillator register selects 800 kHz, overriding configuration.
// - Oscillator register resets to zero, primary frequency in use.
package ldcr_pkg;
   localparam logic [7:0] ADDR_ID    = 8'h03;
   localparam logic [7:0] ADDR_DC    = 8'h07;
   localparam logic [7:0] ADDR_CFG   = 8'h08;
   localparam logic [7:0] ADDR_MASK  = 8'h09;
   localparam logic [7:0] ADDR_PHASE = 8'h0a;
   localparam logic [7:0] ADDR_OSC   = 8'h7f;

   localparam logic [7:0] RST_DC    = 8'hff;
   localparam logic [7:0] RST_CFG   = 8'h1f;
   localparam logic [7:0] RST_MASK  = 8'h3f;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_OSC   = 8'h00;
   localparam logic [7:0] OSC_ALT   = 8'h80;

   localparam int NCH          = 6;
   localparam int ID_TOP_BIT   = 7;
   localparam int CFG_SC_BIT   = 0;
   localparam int CFG_FSW_BIT  = 2;
   localparam int CFG_DRV_LSB  = 3;
   localparam int PH_EVEN_BIT  = 7;
   localparam logic [7:0] PH_DIV = 8'hff;
   localparam logic [1:0] FREQ_1200K = 2'h0;
   localparam logic [1:0] FREQ_600K  = 2'h1;
   localparam logic [1:0] FREQ_800K  = 2'h2;
   localparam logic [3:0] MAKER_NONE = 4'hf;
endpackage

/* design/ldcr_regs.sv */
// LED driver configuration registers, channel mask and phase delay generator.
// Assumes a byte register port from a protocol engine on clk, fault flags and
// the PWM dimming signal arriving asynchronously from the analog side.
`timescale 1ns/1ps
module ldcr_regs #(
   parameter logic [3:0] MAKER_CODE = ldcr_pkg::MAKER_NONE,  // Arbitrary value
   parameter logic [2:0] SILICON_STEP = 3'h0
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   output logic            rvalid,
   input  wire logic [5:0] string_fault,
   input  wire logic       pwm_in,
   output logic      [7:0] dc_current_level,
   output logic      [1:0] fet_drive_strength,
   output logic      [1:0] boost_freq_sel,
   output logic            string_short_detect_enable,
   output logic      [5:0] string_enable,
   output logic      [5:0] string_pwm_on
);
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rst_sync <= 2'h0;
      else       rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   logic [5:0] flt_s1, flt_s2;
   logic [2:0] pwm_s;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flt_s1 <= 6'h00;
         flt_s2 <= 6'h00;
         pwm_s  <= 3'h0;
      end else if (ce) begin
         flt_s1 <= string_fault;
         flt_s2 <= flt_s1;
         pwm_s  <= {pwm_s[1:0], pwm_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] cfg, mask, phase, osc, dc;
   logic [5:0] faulted;
   logic       wr_mask;
   assign wr_mask = wr_en && addr == ldcr_pkg::ADDR_MASK;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dc    <= ldcr_pkg::RST_DC;
         cfg   <= ldcr_pkg::RST_CFG;
         mask  <= ldcr_pkg::RST_MASK;
         phase <= ldcr_pkg::RST_PHASE;
         osc   <= ldcr_pkg::RST_OSC;
      end else if (ce && wr_en) begin
         unique case (addr)
            ldcr_pkg::ADDR_DC:    dc    <= wdata;
            ldcr_pkg::ADDR_CFG:   cfg   <= wdata;
            ldcr_pkg::ADDR_MASK:  mask  <= wdata;
            ldcr_pkg::ADDR_PHASE: phase <= wdata;
            ldcr_pkg::ADDR_OSC:   osc   <= wdata;
            default: ;
         endcase
      end
   end

   // Fault latch per channel: cleared only when its enable bit is written low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) faulted <= 6'h00;
      else if (ce) begin
         for (int i = 0; i < ldcr_pkg::NCH; i++) begin
            if (mask[i] && flt_s2[i]) faulted[i] <= 1'b1;                   // set wins
            else if (wr_mask && !wdata[i]) faulted[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (addr)
         ldcr_pkg::ADDR_ID:    next_rdata = {1'b1, MAKER_CODE, SILICON_STEP};
         ldcr_pkg::ADDR_DC:    next_rdata = dc;
         ldcr_pkg::ADDR_CFG:   next_rdata = cfg;
         ldcr_pkg::ADDR_MASK:  next_rdata = {mask[7:6], mask[5:0] & ~faulted};
         ldcr_pkg::ADDR_PHASE: next_rdata = phase;
         ldcr_pkg::ADDR_OSC:   next_rdata = osc;
         default:              next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata  <= 8'h00;
         rvalid <= 1'b0;
      end else if (ce) begin
         rvalid <= rd_en;
         if (rd_en) rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dc_current_level           <= ldcr_pkg::RST_DC;
         fet_drive_strength         <= ldcr_pkg::RST_CFG[ldcr_pkg::CFG_DRV_LSB +: 2];
         boost_freq_sel             <= ldcr_pkg::FREQ_600K;
         string_short_detect_enable <= ldcr_pkg::RST_CFG[ldcr_pkg::CFG_SC_BIT];
         string_enable              <= ldcr_pkg::RST_MASK[5:0];
      end else if (ce) begin
         dc_current_level   <= dc;
         fet_drive_strength <= cfg[ldcr_pkg::CFG_DRV_LSB +: 2];
         if (osc == ldcr_pkg::OSC_ALT) boost_freq_sel <= ldcr_pkg::FREQ_800K;
         else if (cfg[ldcr_pkg::CFG_FSW_BIT]) boost_freq_sel <= ldcr_pkg::FREQ_600K;
         else boost_freq_sel <= ldcr_pkg::FREQ_1200K;
         string_short_detect_enable <= cfg[ldcr_pkg::CFG_SC_BIT];
         string_enable <= mask[5:0] & ~faulted;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM period measured in clk cycles between rising edges of the dimming input
   logic [23:0] per_cnt, period;
   logic        pwm_rise;
   assign pwm_rise = pwm_s[1] && !pwm_s[2];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         per_cnt <= 24'h000000;
         period  <= 24'h000000;
      end else if (ce) begin
         if (pwm_rise) begin
            period  <= per_cnt + 24'h000001;
            per_cnt <= 24'h000000;
         end else if (per_cnt != 24'hffffff) per_cnt <= per_cnt + 24'h000001;
      end
   end

   function automatic logic [2:0] count_ones(input logic [5:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < ldcr_pkg::NCH; i++) n = n + {2'h0, v[i]};
      return n;
   endfunction

   // Step between successive enabled channels
   logic [2:0]  n_en;
   logic [23:0] step;
   logic [31:0] manual_prod;
   assign n_en = count_ones(string_enable);
   assign manual_prod = 32'(period) * 32'(phase[6:0]);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) step <= 24'h000000;
      else if (ce) begin
         if (phase[ldcr_pkg::PH_EVEN_BIT])
            step <= (n_en == 3'h0) ? 24'h000000 : period / 24'(n_en);
         else
            step <= 24'(manual_prod / 32'(ldcr_pkg::PH_DIV));
      end
   end

   // Per-channel delayed copy of the PWM signal; delays accumulate by rank
   logic [23:0] since_rise;
   logic        pwm_hi;
   logic [23:0] high_len;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         since_rise <= 24'h000000;
         high_len   <= 24'h000000;
      end else if (ce) begin
         if (pwm_rise) since_rise <= 24'h000000;
         else if (since_rise != 24'hffffff) since_rise <= since_rise + 24'h000001;
         if (pwm_s[2] && !pwm_s[1]) high_len <= since_rise + 24'h000001;
      end
   end
   assign pwm_hi = pwm_s[1];

   logic [5:0] next_on;
   always_comb begin
      logic [2:0]  rank;
      logic [23:0] dly;
      logic [23:0] pos;
      rank = 3'h0;
      dly = 24'h000000;
      pos = 24'h000000;
      next_on = 6'h00;
      for (int i = 0; i < ldcr_pkg::NCH; i++) begin
         dly = 24'(step * 24'(rank));
         pos = (since_rise >= dly) ? since_rise - dly : since_rise + period - dly;
         next_on[i] = string_enable[i] && (dly == 24'h000000 ? pwm_hi : (pos < high_len));
         rank = rank + {2'h0, string_enable[i]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) string_pwm_on <= 6'h00;
      else if (ce) string_pwm_on <= next_on;
   end
endmodule // ldcr_regs

/* sim/ldcr_host.sv */
// Register-port host model standing in for the bus protocol engine.
// Assumes requests launched on the falling edge of clk.
`timescale 1ns/1ps
module ldcr_host (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] addr,
   output logic      [7:0] wdata
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr  = 8'h00;
      wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr  = a;
      wdata = (a == ldcr_pkg::ADDR_OSC) ? (d & ldcr_pkg::OSC_ALT) : d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      addr  = ~a;
      wdata = ~wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      addr  = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      addr  = ~a;
      d     = rvalid ? rdata : 8'hxx;
   endtask
endmodule // ldcr_host

/* sim/ldcr_regs_asserts.sv */
// Port checker for the configuration register bank.
// Assumes it is bound onto ldcr_regs and sees only that module's ports.
`timescale 1ns/1ps
module ldcr_regs_asserts #(
   parameter logic [3:0] MAKER_CODE   = 4'hf,
   parameter logic [2:0] SILICON_STEP = 3'h0
) (
   input wire logic       clk, rstn, ce, wr_en, rd_en,
   input wire logic [7:0] addr, wdata, rdata, dc_current_level,
   input wire logic       rvalid, string_short_detect_enable,
   input wire logic [5:0] string_fault, string_enable,
   input wire logic [1:0] fet_drive_strength, boost_freq_sel
);
   logic [7:0] wd1;
   logic [7:0] wd2;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      wd1 <= wdata;
      wd2 <= wd1;
   end
   rd_answer_a: assert property (ce && rd_en |=> rvalid) else $error("read not answered");
   rv_cause_a: assert property (rvalid |-> $past(rd_en)) else $error("stray read strobe");
   id_value_a: assert property (ce && rd_en && addr == ldcr_pkg::ADDR_ID |=>
      rdata == {1'b1, MAKER_CODE, SILICON_STEP}) else $error("identification value wrong");
   dc_follow_a: assert property (ce && wr_en && addr == ldcr_pkg::ADDR_DC ##1 ce |=>
      dc_current_level == wd2) else $error("current level not applied");
   cfg_fields_a: assert property (ce && wr_en && addr == ldcr_pkg::ADDR_CFG ##1 ce |=>
      fet_drive_strength == wd2[4:3] && string_short_detect_enable == wd2[0]) else $error("config not applied");
   alt_osc_a: assert property (ce && wr_en && addr == ldcr_pkg::ADDR_OSC && wdata == ldcr_pkg::OSC_ALT
      ##1 ce |=> boost_freq_sel == ldcr_pkg::FREQ_800K) else $error("alternate oscillator not chosen");
   mask_off_a: assert property (ce && wr_en && addr == ldcr_pkg::ADDR_MASK && wdata[5:0] == 6'h00
      ##1 ce |=> string_enable == 6'h00) else $error("masked channels still enabled");
   fault_drop_a: assert property (ce && string_fault[2] [*6] |=> !string_enable[2])
      else $error("faulted channel still enabled");
endmodule // ldcr_regs_asserts

/* sim/testbench.sv */
// Self-checking bench for the configuration register bank.
// Assumes ldcr_host on the register port and a free-running 160 ns dimming input.
`timescale 1ns/1ps
module testbench;
   logic       clk = 1'b0, rstn = 1'b0, ce = 1'b0, pwm_in = 1'b0;
   logic [5:0] string_fault = 6'h00;
   logic       wr_en, rd_en, rvalid, short_en;
   logic [7:0] addr, wdata, rdata, dc;
   logic [1:0] drive, freq;
   logic [5:0] str_en, pwm_on;
   int         fail_count = 0, checks_done = 0, cyc = 0;
   // Address, reset value, written value, value read back
   logic [31:0] rows [7] = '{32'h03f800f8, 32'h07ff4040, 32'h081fc2c2, 32'h093f1515,
                             32'h0a008585, 32'h7f008080, 32'h55001200};
   always #4 clk = ~clk;
   always #80 pwm_in = ~pwm_in;
   ldcr_regs ldcr_regs_i (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .string_fault(string_fault), .pwm_in(pwm_in),
      .dc_current_level(dc), .fet_drive_strength(drive), .boost_freq_sel(freq),
      .string_short_detect_enable(short_en), .string_enable(str_en), .string_pwm_on(pwm_on));
   ldcr_host ldcr_host_i (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata));
   ////////////////////////////////////////////////////////////////
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value read at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value on outputs at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      ldcr_host_i.rd(a, v);
      chk_rd(v, e);
   endtask
   task automatic pwm_chk(input logic [5:0] early, input logic [5:0] late);
      @(posedge pwm_in);
      repeat (6) @(negedge clk);
      chk_out({2'h0, pwm_on}, {2'h0, early});
      repeat (10) @(negedge clk);
      chk_out({2'h0, pwm_on}, {2'h0, late});
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      ce   = 1'b1;
      repeat (3) @(negedge clk);
      chk_out({drive, freq, short_en, str_en[5:3]}, {2'h3, ldcr_pkg::FREQ_600K, 1'b1, 3'h7});
      for (int i = 0; i < 7; i++) begin
         rdc(rows[i][31:24], rows[i][23:16]);
         ldcr_host_i.wr(rows[i][31:24], rows[i][15:8]);
         rdc(rows[i][31:24], rows[i][7:0]);
      end
      chk_out(dc, 8'h40);
      chk_out({drive, freq, short_en, 3'h0}, {2'h0, ldcr_pkg::FREQ_800K, 1'b0, 3'h0});
      ldcr_host_i.wr(ldcr_pkg::ADDR_OSC, 8'h00);
      repeat (2) @(negedge clk);
      chk_out({6'h0, freq}, {6'h0, ldcr_pkg::FREQ_1200K});
      for (int d = 0; d < 4; d++) begin
         ldcr_host_i.wr(ldcr_pkg::ADDR_CFG, {3'h0, d[1:0], 3'h5});
         repeat (2) @(negedge clk);
         chk_out({drive, freq, short_en, 3'h0}, {d[1:0], ldcr_pkg::FREQ_600K, 1'b1, 3'h0});
      end
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h3f);
      string_fault = 6'h04;
      repeat (8) @(negedge clk);
      string_fault = 6'h00;
      rdc(ldcr_pkg::ADDR_MASK, 8'h3b);
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h3b);
      repeat (4) @(negedge clk);
      chk_out({2'h0, str_en}, 8'h3b);
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h3f);
      repeat (8) @(negedge clk);
      rdc(ldcr_pkg::ADDR_MASK, 8'h3f);
      ldcr_host_i.wr(ldcr_pkg::ADDR_PHASE, 8'h00);
      repeat (100) @(negedge clk);
      pwm_chk(6'h3f, 6'h00);
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h05);
      ldcr_host_i.wr(ldcr_pkg::ADDR_PHASE, 8'h80);
      repeat (100) @(negedge clk);
      pwm_chk(6'h01, 6'h04);
      // Three channels, code 127: step of 9 cycles, span 18 stays inside one period
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h07);
      ldcr_host_i.wr(ldcr_pkg::ADDR_PHASE, 8'h7f);
      repeat (100) @(negedge clk);
      pwm_chk(6'h05, 6'h02);
      ldcr_host_i.wr(ldcr_pkg::ADDR_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chk_out({2'h0, str_en}, 8'h00);
      complete_run();
   end
endmodule // testbench
bind ldcr_regs ldcr_regs_asserts #(.MAKER_CODE(MAKER_CODE), .SILICON_STEP(SILICON_STEP)) ldcr_regs_asserts_i (
   .clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
   .dc_current_level(dc_current_level), .rvalid(rvalid), .string_short_detect_enable(string_short_detect_enable),
   .string_fault(string_fault), .string_enable(string_enable), .fet_drive_strength(fet_drive_strength),
   .boost_freq_sel(boost_freq_sel));
